// *** ewdt_watchdog.sv ***
// watchdog countdown timer with APB register access.
// assumes clk_32k arrives as an asynchronous pin; hold sources are asynchronous levels.
// all logic runs on pclk; the slow clock becomes a one-cycle enable pulse.

module ewdt_watchdog
	import ewdt_pkg::*;
#(
	parameter int STEP_TICKS = EWDT_TICKS_PER_STEP
) (
	// apb clock and system reset
	input wire logic pclk,
	input wire logic presetn,
	// reset kept over expiry, active low
	input wire logic keep_rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// slow clock pin and hold sources
	input wire logic clk_32k,
	input wire logic debug_active,
	input wire logic week_timer_active,
	input wire logic sleep_timer0_active,
	// flag clear from the reset status register
	input wire logic watchdog_flag_clear,
	// expiry, flag and clock gating
	output logic expiry_reset_pulse,
	output logic watchdog_flag,
	output logic func_clk_en
);

	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [15:0] reload_q;
	logic [7:0] ctrl_q;
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic [5:0] pre_q;
	logic [5:0] pre_d;
	logic expiry_q;
	logic flag_q;
	logic clk_en_q;
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic [3:0] sync3_q;
	logic [3:0] filt_q;
	logic [3:0] filt_d;

	// counter holds two resets: system and kept-over-expiry
	wire count_rst_n = presetn & keep_rst_n;

	// apb decode
	wire setup = psel & ~penable;
	wire access = psel & penable & pready_q;
	wire wr = access & pwrite;
	wire hit_reload = (paddr == EWDT_OFS_RELOAD);
	wire hit_ctrl = (paddr == EWDT_OFS_CONTROL);
	wire hit_restart = (paddr == EWDT_OFS_RESTART);
	wire hit_count = (paddr == EWDT_OFS_COUNT);
	wire hit_any = hit_reload | hit_ctrl | hit_restart | hit_count;
	wire wr_reload = wr & hit_reload & ~pslverr_q;
	wire wr_ctrl = wr & hit_ctrl & ~pslverr_q;
	wire wr_restart = wr & hit_restart & ~pslverr_q;

	// control fields
	wire en = ctrl_q[EWDT_BIT_ENABLE];
	wire [7:0] ctrl_wr_val = pwdata[7:0] & EWDT_CTRL_WMASK;
	wire en_rise = wr_ctrl & ~en & ctrl_wr_val[EWDT_BIT_ENABLE];

	// read data, registered in the setup cycle so the access completes at once
	wire [31:0] rd_mux = hit_reload ? {16'h0000, reload_q} :
		hit_ctrl ? {24'h000000, ctrl_q} :
		hit_count ? {16'h0000, count_q} : 32'h00000000;

	// apb response: no wait for the slow clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			if (setup) begin
				prdata_q <= pwrite ? 32'h00000000 : rd_mux;
				pslverr_q <= ~hit_any;
			end else if (access) begin
				pslverr_q <= 1'b0;
			end
		end
	end

	// software registers under system reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_q <= EWDT_RST_RELOAD;
			ctrl_q <= EWDT_RST_CONTROL;
		end else begin
			if (wr_reload)
				reload_q <= pwdata[15:0];
			if (wr_ctrl)
				ctrl_q <= ctrl_wr_val;
		end
	end

	// three-stage synchronisers: slow clock and the hold sources
	wire [3:0] pins = {sleep_timer0_active, week_timer_active, debug_active, clk_32k};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
			sync3_q <= 4'h0;
			filt_q <= 4'h0;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			filt_q <= filt_d;
		end
	end

	// a change counts once stages two and three agree
	wire [3:0] agree = ~(sync2_q ^ sync3_q);
	assign filt_d = (agree & sync3_q) | (~agree & filt_q);

	// one pulse per slow clock rising edge
	wire tick = filt_d[0] & ~filt_q[0];

	// hold request from enabled sources
	wire hold = (filt_q[1] & ctrl_q[EWDT_BIT_DEBUG_HOLD])
		| (filt_q[2] & ctrl_q[EWDT_BIT_WEEK_HOLD])
		| (filt_q[3] & ctrl_q[EWDT_BIT_SLEEP0_HOLD]);

	// a disabled or held counter neither steps nor advances its prescaler
	wire run = en & ~hold;
	wire step_tick = run & tick;
	wire step = step_tick & (pre_q == 6'(STEP_TICKS - 1));
	wire underflow = step & (count_q == 16'h0000);

	// software reload wins over an underflow in the same cycle
	wire sw_reload = wr_reload | (wr_restart & en) | en_rise;
	wire expire = underflow & ~sw_reload;
	wire [15:0] reload_src = wr_reload ? pwdata[15:0] : reload_q;

	// next count and prescaler
	always_comb begin
		count_d = count_q;
		pre_d = pre_q;
		if (sw_reload | expire) begin
			count_d = reload_src;
			pre_d = 6'h00;
		end else if (step) begin
			count_d = count_q - 16'h0001;
			pre_d = 6'h00;
		end else if (step_tick) begin
			pre_d = pre_q + 6'h01;
		end
	end

	// countdown registers
	always_ff @(posedge pclk or negedge count_rst_n) begin
		if (!count_rst_n) begin
			count_q <= EWDT_RST_COUNT;
			pre_q <= 6'h00;
		end else begin
			count_q <= count_d;
			pre_q <= pre_d;
		end
	end

	// expiry pulse spans one slow clock period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			expiry_q <= 1'b0;
			clk_en_q <= 1'b0;
		end else begin
			if (expire)
				expiry_q <= 1'b1;
			else if (tick)
				expiry_q <= 1'b0;
			clk_en_q <= run;
		end
	end

	// sticky flag survives the system reset that expiry causes; set wins
	always_ff @(posedge pclk or negedge keep_rst_n) begin
		if (!keep_rst_n)
			flag_q <= 1'b0;
		else if (expire)
			flag_q <= 1'b1;
		else if (watchdog_flag_clear)
			flag_q <= 1'b0;
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign expiry_reset_pulse = expiry_q;
	assign watchdog_flag = flag_q;
	assign func_clk_en = clk_en_q;

endmodule

// *** ewdt_pkg.sv ***
// register map, field positions, reset values and timing counts of the watchdog.
// assumes a 32-bit APB slave with one aligned word per register.
package ewdt_pkg;

	// register byte offsets
	localparam logic [11:0] EWDT_OFS_RELOAD = 12'h000;
	localparam logic [11:0] EWDT_OFS_CONTROL = 12'h004;
	localparam logic [11:0] EWDT_OFS_RESTART = 12'h008;
	localparam logic [11:0] EWDT_OFS_COUNT = 12'h00c;

	// control field positions
	localparam int EWDT_BIT_ENABLE = 0;
	localparam int EWDT_BIT_TEST = 1;
	localparam int EWDT_BIT_SLEEP0_HOLD = 2;
	localparam int EWDT_BIT_WEEK_HOLD = 3;
	localparam int EWDT_BIT_DEBUG_HOLD = 4;

	// reset values
	localparam logic [15:0] EWDT_RST_RELOAD = 16'hffff;
	localparam logic [15:0] EWDT_RST_COUNT = 16'hffff;
	localparam logic [7:0] EWDT_RST_CONTROL = 8'h00;

	// slow clock periods per count step
	localparam int EWDT_TICKS_PER_STEP = 33;

	// writable control bits (enable and the three hold enables)
	localparam logic [7:0] EWDT_CTRL_WMASK = 8'h1d;

endpackage

// *** ewdt_checker.sv ***
// port-level assertions for the watchdog.
// assumes a slow clock at most 40 times slower than pclk.
module ewdt_checker (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// expiry side
	input wire logic expiry_reset_pulse,
	input wire logic watchdog_flag,
	input wire logic func_clk_en
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// setup phase decode
	logic setup;
	assign setup = psel && !penable;
	a_ready_after_setup: assert property (setup |=> pready) else $error("no ready");
	a_ready_single: assert property (pready |=> !pready) else $error("ready held");
	a_ready_cause: assert property (!setup |=> !pready) else $error("stray ready");
	a_unmapped_err: assert property (setup && paddr > 12'h00c |=> pslverr)
		else $error("no error");
	a_mapped_ok: assert property (setup && paddr[1:0] == 0 && paddr <= 12'h00c |=> !pslverr)
		else $error("false error");
	a_restart_zero: assert property (setup && !pwrite && paddr == 12'h008 |=> prdata == 0)
		else $error("restart read");
	a_ctrl_rsvd_zero: assert property (setup && !pwrite && paddr == 12'h004
		|=> prdata[31:5] == 0 && !prdata[1]) else $error("reserved bits");
	a_expiry_flag: assert property ($rose(expiry_reset_pulse) |-> ##[0:1] watchdog_flag)
		else $error("flag not set");
	// pulse ends within 40 pclk cycles, one slow period at most
	a_expiry_ends: assert property (expiry_reset_pulse |-> ##[1:40] !expiry_reset_pulse)
		else $error("pulse stuck");
	c_expiry: cover property ($rose(expiry_reset_pulse));
	c_err: cover property (pslverr);
	c_gate: cover property ($fell(func_clk_en));
endmodule
bind ewdt_watchdog ewdt_checker i_ewdt_checker (.*);

// *** testbench.sv ***
// self-checking apb bench for the watchdog.
// assumes a sped-up slow clock and STEP_TICKS of 2 for short runs.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, keep_rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic clk_32k = 0, flag_clr = 0;
	logic [2:0] hold = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic pready, pslverr, expiry_reset_pulse, watchdog_flag, func_clk_en;
	logic [31:0] rv[5] = '{32'hffff, 0, 0, 32'hffff, 0};
	int failures = 0, n_checks = 0, i, k;
	// slow clock at 5 MHz so a count step takes 20 pclk
	always #10 pclk = ~pclk;
	always #100 clk_32k = ~clk_32k;
	ewdt_watchdog #(.STEP_TICKS(2)) i_ewdt_watchdog (.pclk, .presetn, .keep_rst_n, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .clk_32k,
		.debug_active(hold[2]), .week_timer_active(hold[1]), .sleep_timer0_active(hold[0]),
		.watchdog_flag_clear(flag_clr), .expiry_reset_pulse, .watchdog_flag, .func_clk_en);
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
	task end_sim;
		if (failures == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// one apb transfer; read data lands in q
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int t;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// request stands until the rising edge that samples pready high
		for (t = 0; t < 20; t++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (t == 20) begin
			failures++;
			end_sim();
		end
		q = prdata;
		psel <= 0;
		penable <= 0;
	endtask
	task wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		keep_rst_n <= 1;
		for (i = 0; i < 5; i++) begin
			apb(0, 12'(4 * i), 0);
			`CHK("reset read", rv[i], q)
		end
		apb(1, 12'h004, 32'hff);
		apb(0, 12'h004, 0);
		`CHK("ctrl mask", 32'h1d, q)
		apb(1, 12'h004, 0);
		apb(1, 12'h000, 5);
		wt(100);
		apb(0, 12'h00c, 0);
		`CHK("disabled", 32'h5, q)
		`CHK("gate off", 1'b0, func_clk_en)
		for (i = 0; i < 3; i++) begin
			apb(1, 12'h000, 32'h100);
			hold <= 3'(1 << i);
			apb(1, 12'h004, 1);
			wt(100);
			apb(0, 12'h00c, 0);
			`CHK("hold ignored", 1'b1, q < 32'h100)
			apb(1, 12'h004, 32'(1 | 4 << i));
			wt(10);
			apb(1, 12'h008, 0);
			wt(100);
			apb(0, 12'h00c, 0);
			`CHK("held", 32'h100, q)
			`CHK("gated", 1'b0, func_clk_en)
			hold <= 0;
			wt(100);
			apb(0, 12'h00c, 0);
			`CHK("resumed", 1'b1, q < 32'h100)
		end
		// short interval kept alive by restart writes well inside it
		apb(1, 12'h000, 3);
		for (i = 0; i < 8; i++) begin
			wt(10);
			apb(1, 12'h008, 0);
		end
		`CHK("kicked", 1'b0, watchdog_flag)
		apb(1, 12'h000, 0);
		for (k = 0; k < 500 && expiry_reset_pulse !== 1'b1; k++) @(negedge pclk);
		@(negedge pclk);
		`CHK("expiry", 1'b1, expiry_reset_pulse)
		`CHK("flag", 1'b1, watchdog_flag)
		if (k == 500) end_sim();
		apb(0, 12'h00c, 0);
		`CHK("reloaded", 32'h0, q)
		// disable, clear the flag, then let a fresh expiry set it again
		apb(1, 12'h004, 0);
		flag_clr <= 1;
		wt(1);
		flag_clr <= 0;
		wt(1);
		`CHK("flag clear", 1'b0, watchdog_flag)
		apb(1, 12'h004, 1);
		wt(60);
		`CHK("flag again", 1'b1, watchdog_flag)
		presetn <= 0;
		wt(2);
		`CHK("pulse clear", 1'b0, expiry_reset_pulse)
		presetn <= 1;
		apb(0, 12'h000, 0);
		`CHK("reload reset", 32'hffff, q)
		`CHK("flag kept", 1'b1, watchdog_flag)
		apb(1, 12'h000, 5);
		keep_rst_n <= 0;
		wt(2);
		`CHK("flag reset", 1'b0, watchdog_flag)
		keep_rst_n <= 1;
		apb(0, 12'h00c, 0);
		`CHK("count reset", 32'hffff, q)
		end_sim();
	end
endmodule
